// ---- src/ambient_config_defines.vh ----
// register map, field positions and mode codes of the ambient configuration logic
// Summary of operation
// - irq channel select 00 clear, 01 green, 10 infrared, 11 temperature.
// - mode 000 clear, 001 clear plus IR, 010 clear RGB and IR.
// - mode 011 and 100 interleave their ambient set with proximity conversions.
// - mode 101 proximity only continuous; 110 and 111 reserved, nothing converts.
// - temperature converts in ambient modes only while its enable bit is one.
// - 8-bit RW ambient config at 0x02, reset 0x00, trim/comp/temp/time/gain fields.
// - ambient config write aborts conversion, applies settings now, restarts.
// - gain code sets ambient channel weight per count, 2/8/32/512 for clear.
// - 400ms integration gives a quarter weight per count versus 100ms.
// - main config write never aborts; new settings apply next conversion period.
`ifndef AMBIENT_CONFIG_DEFINES_VH
`define AMBIENT_CONFIG_DEFINES_VH
`define ADDR_MAIN_CFG      8'h01
`define ADDR_AMB_CFG       8'h02
`define MAIN_CFG_RESET     8'h20
`define AMB_CFG_RESET      8'h00
`define MODE_RESET         3'h1
`define SEL_RESET          2'h0
`define TIME_RESET         3'h0
`define GAIN_RESET         2'h0
`define RDATA_NONE         8'h00
`define CH_NONE            7'h00
`define CH_AMB_SET         5'h1F
`define GAIN_CODE0         2'h0
`define GAIN_CODE1         2'h1
`define GAIN_CODE2         2'h2
`define MODE_MSB           7
`define MODE_LSB           5
`define SEL_MSB            4
`define SEL_LSB            3
`define TRIM_BIT           7
`define COMP_BIT           6
`define TEMP_BIT           5
`define TIME_MSB           4
`define TIME_LSB           2
`define GAIN_MSB           1
`define GAIN_LSB           0
`define MODE_CLEAR         3'h0
`define MODE_CLEAR_IR      3'h1
`define MODE_CLEAR_RGB_IR  3'h2
`define MODE_CLEAR_IR_PROX 3'h3
`define MODE_ALL_PROX      3'h4
`define MODE_PROX_ONLY     3'h5
`define SEL_CLEAR          2'h0
`define SEL_GREEN          2'h1
`define SEL_IR             2'h2
`define SEL_TEMP           2'h3
`define TIME_400MS         3'h4
// clear-channel weight per count at 100 ms, in quarter nW/cm2 so 400 ms stays integral
`define WEIGHT_GAIN0       12'h008
`define WEIGHT_GAIN1       12'h020
`define WEIGHT_GAIN2       12'h080
`define WEIGHT_GAIN3       12'h800
`define WEIGHT_SHIFT_400   2
// channel enable vector bits
`define CH_CLEAR           0
`define CH_RED             1
`define CH_GREEN           2
`define CH_BLUE            3
`define CH_IR              4
`define CH_TEMP            5
`define CH_PROX            6
`endif

// ---- src/ambient_channel_mode_config.v ----
// register holding and decoding for the ambient channel and mode configuration
`timescale 1ns/100ps
`include "ambient_config_defines.vh"
module ambient_channel_mode_config (
	// clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// register access from the serial interface logic
	input  wire        regWrite,
	input  wire        regRead,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWdata,
	output reg  [7:0]  regRdata,
	// conversion sequencer handshake
	input  wire        periodStart,
	output reg         ambAbort,
	output reg         ambStart,
	// decoded settings
	output reg  [6:0]  channelEnable,
	output reg         interleave,
	output reg  [1:0]  irq_channel_select,
	output reg         trimEnable,
	output reg         ir_comp_enable,
	output reg         temp_sensor_enable,
	output reg  [2:0]  integration_time_code,
	output reg  [1:0]  ambient_gain_code,
	output reg  [11:0] clearWeightQuarter
);
	// register images as the host wrote them
	reg  [7:0]  mainCfg;
	reg  [7:0]  ambient_measure_config;
	// main settings in force for the running conversion period
	reg  [2:0]  activeMode;
	// combinational next values
	reg  [7:0]  next_mainCfg;
	reg  [7:0]  next_ambCfg;
	reg  [2:0]  next_activeMode;
	reg  [1:0]  next_select;
	reg  [7:0]  next_regRdata;
	reg  [6:0]  next_channelEnable;
	reg         next_interleave;
	reg  [11:0] baseWeight;
	reg  [11:0] next_weight;
	// decoded write strobes
	wire        mainWr;
	wire        ambWr;
	wire [7:0]  ambNow;

	assign mainWr = regWrite && (regAddr == `ADDR_MAIN_CFG);
	assign ambWr  = regWrite && (regAddr == `ADDR_AMB_CFG);
	// ambient settings act on the write edge itself, not a cycle later
	assign ambNow = ambWr ? regWdata : ambient_measure_config;

	// main configuration image
	always @* begin
		next_mainCfg = mainCfg;
		if (mainWr)
			next_mainCfg = regWdata;
	end

	always @(posedge mclk) begin
		if (!nrst)
			mainCfg <= `MAIN_CFG_RESET;
		else
			mainCfg <= next_mainCfg;
	end

	// main settings wait for the period boundary
	// a write in the boundary cycle itself waits one more period
	always @* begin
		next_activeMode = activeMode;
		next_select = irq_channel_select;
		if (periodStart) begin
			next_activeMode = mainCfg[`MODE_MSB:`MODE_LSB];
			// source of the ambient threshold comparison
			next_select = mainCfg[`SEL_MSB:`SEL_LSB];
		end
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			activeMode <= `MODE_RESET;
			irq_channel_select <= `SEL_RESET;
		end else begin
			activeMode <= next_activeMode;
			irq_channel_select <= next_select;
		end
	end

	always @* begin
		next_ambCfg = ambient_measure_config;
		if (ambWr)
			next_ambCfg = regWdata;
	end

	always @(posedge mclk) begin
		if (!nrst)
			ambient_measure_config <= `AMB_CFG_RESET;
		else
			ambient_measure_config <= next_ambCfg;
	end

	// abort the running conversion and start afresh
	always @(posedge mclk) begin
		if (!nrst) begin
			ambAbort <= 1'b0;
			ambStart <= 1'b0;
		end else begin
			ambAbort <= ambWr;
			ambStart <= ambWr;
		end
	end

	// unmapped addresses read as zero; a read value stands until the next read
	always @* begin
		next_regRdata = regRdata;
		if (regRead) begin
			case (regAddr)
			`ADDR_MAIN_CFG: next_regRdata = mainCfg;
			`ADDR_AMB_CFG: next_regRdata = ambient_measure_config;
			default: next_regRdata = `RDATA_NONE;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!nrst)
			regRdata <= `RDATA_NONE;
		else
			regRdata <= next_regRdata;
	end

	// mode decode; reserved codes enable nothing, a safe outcome for a host slip
	always @* begin
		next_channelEnable = `CH_NONE;
		next_interleave = 1'b0;
		case (activeMode)
		`MODE_CLEAR: begin
			next_channelEnable[`CH_CLEAR] = 1'b1;
		end
		`MODE_CLEAR_IR: begin
			next_channelEnable[`CH_CLEAR] = 1'b1;
			next_channelEnable[`CH_IR] = 1'b1;
		end
		`MODE_CLEAR_RGB_IR: begin
			next_channelEnable[`CH_IR:`CH_CLEAR] = `CH_AMB_SET;
		end
		`MODE_CLEAR_IR_PROX: begin
			next_channelEnable[`CH_CLEAR] = 1'b1;
			next_channelEnable[`CH_IR] = 1'b1;
			next_channelEnable[`CH_PROX] = 1'b1;
			next_interleave = 1'b1;
		end
		`MODE_ALL_PROX: begin
			next_channelEnable[`CH_IR:`CH_CLEAR] = `CH_AMB_SET;
			next_channelEnable[`CH_PROX] = 1'b1;
			next_interleave = 1'b1;
		end
		`MODE_PROX_ONLY: begin
			next_channelEnable[`CH_PROX] = 1'b1;
		end
		default: begin
			next_channelEnable = `CH_NONE;
		end
		endcase
		// temperature follows clear and its enable
		next_channelEnable[`CH_TEMP] = next_channelEnable[`CH_CLEAR] & ambNow[`TEMP_BIT];
	end

	// clear weight per count from the gain code
	always @* begin
		case (ambNow[`GAIN_MSB:`GAIN_LSB])
		`GAIN_CODE0: baseWeight = `WEIGHT_GAIN0;
		`GAIN_CODE1: baseWeight = `WEIGHT_GAIN1;
		`GAIN_CODE2: baseWeight = `WEIGHT_GAIN2;
		default: baseWeight = `WEIGHT_GAIN3;
		endcase
	end

	// quarter weight at 400 ms
	// the shorter times are left at the 100 ms figure; the host scales them
	always @* begin
		next_weight = baseWeight;
		if (ambNow[`TIME_MSB:`TIME_LSB] == `TIME_400MS)
			next_weight = baseWeight >> `WEIGHT_SHIFT_400;
	end

	// ambient settings registered the same edge as the write; mode enables and interleave a cycle after activeMode
	always @(posedge mclk) begin
		if (!nrst) begin
			channelEnable <= `CH_NONE;
			interleave <= 1'b0;
			trimEnable <= 1'b0;
			ir_comp_enable <= 1'b0;
			temp_sensor_enable <= 1'b0;
			integration_time_code <= `TIME_RESET;
			ambient_gain_code <= `GAIN_RESET;
			clearWeightQuarter <= `WEIGHT_GAIN0;
		end else begin
			channelEnable <= next_channelEnable;
			interleave <= next_interleave;
			trimEnable <= ambNow[`TRIM_BIT];
			ir_comp_enable <= ambNow[`COMP_BIT];
			temp_sensor_enable <= ambNow[`TEMP_BIT];
			integration_time_code <= ambNow[`TIME_MSB:`TIME_LSB];
			ambient_gain_code <= ambNow[`GAIN_MSB:`GAIN_LSB];
			clearWeightQuarter <= next_weight;
		end
	end
endmodule

// ---- verif/host_model.sv ----
// host side register access model
`timescale 1ns/100ps
module host_model (
	input  wire       mclk,
	output reg        regWrite,
	output reg        regRead,
	output reg  [7:0] regAddr,
	output reg  [7:0] regWdata
);
	initial {regWrite, regRead, regAddr, regWdata} = 18'h00000;
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge mclk);
		{regWrite, regRead, regAddr, regWdata} <= {w, !w, a, d};
		@(posedge mclk);
		{regWrite, regRead} <= 2'h0;
	endtask
endmodule

// ---- verif/ambient_config_assertions.sv ----
// port checker of the ambient configuration logic
`timescale 1ns/100ps
module ambient_config_checker (
	input logic        mclk, nrst, regWrite, periodStart, ambAbort, ambStart, interleave,
	input logic        trimEnable, ir_comp_enable, temp_sensor_enable,
	input logic [7:0]  regAddr, regWdata,
	input logic [6:0]  channelEnable,
	input logic [1:0]  irq_channel_select, ambient_gain_code,
	input logic [2:0]  integration_time_code,
	input logic [11:0] clearWeightQuarter
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire [7:0]  amb = {trimEnable, ir_comp_enable, temp_sensor_enable,
		integration_time_code, ambient_gain_code};
	wire        ambWr = regWrite && regAddr == 8'h02;
	wire [11:0] w = ambient_gain_code == 2'h3 ? 12'h800 : 12'h008 << 2 * ambient_gain_code;
	AST_ABORT: assert property (ambWr |=> ambAbort && ambStart) else $error("abort");
	AST_NOABORT: assert property (ambAbort |-> $past(ambWr)) else $error("stray");
	AST_FIELDS: assert property (ambWr |=> amb == $past(regWdata)) else $error("fields");
	AST_GAIN: assert property (integration_time_code == 3'h0 |->
		clearWeightQuarter == w) else $error("gain");
	AST_QUARTER: assert property (integration_time_code == 3'h4 |->
		clearWeightQuarter == w >> 2) else $error("quarter");
	AST_SELECT: assert property ($changed(irq_channel_select) |->
		$past(periodStart)) else $error("select");
	AST_TEMP: assert property (channelEnable[5] |->
		temp_sensor_enable && channelEnable[0]) else $error("temp");
	AST_MIX: assert property (interleave |-> channelEnable[6] && channelEnable[0])
		else $error("interleave");
	cover property (ambWr);
	cover property (interleave);
	cover property (channelEnable == 7'h40);
endmodule
bind ambient_channel_mode_config ambient_config_checker ambient_config_checker_i (
	.mclk                  (mclk),
	.nrst                  (nrst),
	.regWrite              (regWrite),
	.periodStart           (periodStart),
	.ambAbort              (ambAbort),
	.ambStart              (ambStart),
	.interleave            (interleave),
	.trimEnable            (trimEnable),
	.ir_comp_enable        (ir_comp_enable),
	.temp_sensor_enable    (temp_sensor_enable),
	.regAddr               (regAddr),
	.regWdata              (regWdata),
	.channelEnable         (channelEnable),
	.irq_channel_select    (irq_channel_select),
	.ambient_gain_code     (ambient_gain_code),
	.integration_time_code (integration_time_code),
	.clearWeightQuarter    (clearWeightQuarter)
);

// ---- verif/ambient_channel_mode_config_test.sv ----
// self-checking bench of the ambient configuration logic
`timescale 1ns/100ps
module ambient_channel_mode_config_test;
	logic        mclk = 1'b0, nrst = 1'b0, periodStart = 1'b0;
	logic        regWrite, regRead, ambAbort, ambStart, interleave;
	logic        trimEnable, ir_comp_enable, temp_sensor_enable;
	logic [7:0]  regAddr, regWdata, regRdata;
	logic [6:0]  channelEnable;
	logic [1:0]  irq_channel_select, ambient_gain_code;
	logic [2:0]  integration_time_code;
	logic [11:0] clearWeightQuarter;
	logic [6:0]  modeCh [6] = '{7'h21, 7'h31, 7'h3F, 7'h71, 7'h7F, 7'h40};
	int          mismatches = 0, cmp_count = 0, cycles = 0;
	always #2.5 mclk = ~mclk;
	host_model host_model_i (
		.mclk     (mclk),
		.regWrite (regWrite),
		.regRead  (regRead),
		.regAddr  (regAddr),
		.regWdata (regWdata)
	);
	ambient_channel_mode_config ambient_channel_mode_config_i (
		.mclk                  (mclk),
		.nrst                  (nrst),
		.regWrite              (regWrite),
		.regRead               (regRead),
		.regAddr               (regAddr),
		.regWdata              (regWdata),
		.regRdata              (regRdata),
		.periodStart           (periodStart),
		.ambAbort              (ambAbort),
		.ambStart              (ambStart),
		.channelEnable         (channelEnable),
		.interleave            (interleave),
		.irq_channel_select    (irq_channel_select),
		.trimEnable            (trimEnable),
		.ir_comp_enable        (ir_comp_enable),
		.temp_sensor_enable    (temp_sensor_enable),
		.integration_time_code (integration_time_code),
		.ambient_gain_code     (ambient_gain_code),
		.clearWeightQuarter    (clearWeightQuarter)
	);
	task chk(input string n, input logic [11:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// answers stand just after the taking edge; pulses last only that cycle
	task acc(input logic w, input logic [7:0] a, d);
		host_model_i.acc(w, a, d);
		#1;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			end_of_test;
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		acc(0, 8'h02, 8'h00);
		chk("ambReset", regRdata, 12'h000);
		chk("resetCh", channelEnable, 12'h011);
		chk("resetWeight", clearWeightQuarter, 12'h008);
		acc(1, 8'h02, 8'hE4);
		chk("restart", {ambAbort, ambStart}, 12'h003);
		chk("fields", {trimEnable, ir_comp_enable, temp_sensor_enable, integration_time_code, ambient_gain_code}, 12'h0E4);
		chk("tempCh", channelEnable, 12'h031);
		acc(0, 8'h02, 8'h00);
		chk("ambRead", regRdata, 12'h0E4);
		for (int t = 0; t < 5; t += 4)
			for (int g = 0; g < 4; g++) begin
				acc(1, 8'h02, 8'(32 | t << 2 | g));
				chk("weight", clearWeightQuarter, 12'(8 << 2 * g + 2 * (g / 3) >> t / 2));
			end
		for (int m = 0; m < 6; m++) begin
			acc(1, 8'h01, 8'(m << 5 | m % 4 << 3));
			chk("noAbort", ambAbort, 12'h000);
			@(posedge mclk) periodStart <= 1'b1;
			@(posedge mclk) periodStart <= 1'b0;
			repeat (2) @(posedge mclk);
			#1;
			chk("select", irq_channel_select, 12'(m % 4));
			chk("channels", channelEnable, 12'(modeCh[m]));
			chk("interleave", interleave, 12'(m == 3 || m == 4));
		end
		end_of_test;
	end
endmodule
